//--- hdl/spimds_top.sv
// Decoded-select SPI master moving single bytes full duplex.
// Functional notes
// - Drive three-bit select code to decoder.
// - Code seven is the null slave.
// - Reset select code rests on null slave.
// - New stream reselects slave after null.
// - Transmit sets select before shifting byte.
// - Every request carries its own target.
// - Select code may change without data.
// - Receive sends caller byte, default zero.
// - Receive returns the shifted-in byte.
// - Positions zero to two, six are fixed.
// - Clock settings kept per slave position.
// - Settings applied once on new selection.
`timescale 1ns/1ns
`include "spimds_defs.svh"
module spimds_top
	import spimds_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic req_valid_i,
	output logic req_ready_o,
	input wire logic [1:0] req_op_i,
	input wire logic [2:0] req_code_i,
	input wire logic req_has_data_i,
	input wire logic [7:0] req_data_i,
	input wire logic cfg_wr_i,
	input wire logic [2:0] cfg_code_i,
	input wire logic [7:0] cfg_div_i,
	input wire logic cfg_cpol_i,
	input wire logic cfg_cpha_i,
	output logic cfg_err_o,
	output logic select_code_bit0_o,
	output logic select_code_bit1_o,
	output logic select_code_bit2_o,
	output logic sclk_o,
	output logic mosi_o,
	input wire logic miso_i,
	output logic rx_valid_o,
	output logic [7:0] rx_data_o,
	output logic busy_o,
	output logic new_stream_o
);
	spimds_state_t state_q;
	logic [2:0] slave_position_code_q;
	logic [2:0] applied_code_q;
	logic applied_valid_q;
	spimds_cfg_t act_cfg_q;
	spimds_cfg_t tbl_cfg;
	logic [7:0] div_cnt_q;
	logic [3:0] bit_cnt_q;
	logic phase_q;
	logic [7:0] tx_sh_q;
	logic [7:0] rx_sh_q;
	logic is_rx_q;
	logic rx_valid_q;
	logic [7:0] rx_data_q;
	logic cfg_err_q;
	logic new_stream_q;
	logic sclk_q;
	logic [12:0] fifo_in;
	logic [12:0] fifo_out;
	logic fifo_valid;
	logic fifo_pop;
	logic tick;
	logic [1:0] f_op;
	logic [2:0] f_code;
	logic [7:0] f_data;
	logic cfg_user_ok;
	logic cfg_wr_ok;

	////////////////////////////////////////////////////////////////////////
	// Requests queue here; ready drops when the queue is full.
	assign fifo_in = {req_op_i, req_code_i,
		(req_has_data_i ? req_data_i : `SPIMDS_NULL_DATA)};

	spimds_fifo #(
		.WIDTH(`SPIMDS_FIFO_WIDTH),
		.DEPTH(`SPIMDS_FIFO_DEPTH)
	) u_fifo (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.in_valid_i(req_valid_i),
		.in_ready_o(req_ready_o),
		.in_data_i(fifo_in),
		.out_valid_o(fifo_valid),
		.out_ready_i(fifo_pop),
		.out_data_o(fifo_out)
	);

	assign f_op = fifo_out[12:11];
	assign f_code = fifo_out[10:8];
	assign f_data = fifo_out[7:0];
	// The engine takes a request only when idle, so the queue holds the rest.
	assign fifo_pop = (state_q == SPIMDS_IDLE) && fifo_valid;

	////////////////////////////////////////////////////////////////////////
	// Settings for the fixed on-board positions cannot be overwritten.
	assign cfg_user_ok = (cfg_code_i >= `SPIMDS_USER_SLAVE_CODE_A) &&
		(cfg_code_i <= `SPIMDS_USER_SLAVE_CODE_C);
	assign cfg_wr_ok = cfg_wr_i && cfg_user_ok;

	spimds_cfg_table u_cfg (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.wr_i(cfg_wr_ok),
		.wr_code_i(cfg_code_i),
		.wr_div_i(cfg_div_i),
		.wr_cpol_i(cfg_cpol_i),
		.wr_cpha_i(cfg_cpha_i),
		.rd_code_i(slave_position_code_q),
		.rd_cfg_o(tbl_cfg)
	);

	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
			cfg_err_q <= 1'b0;
		else
			cfg_err_q <= cfg_wr_i && !cfg_user_ok;
	end

	////////////////////////////////////////////////////////////////////////
	// Sequencer.
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
			state_q <= SPIMDS_IDLE;
		else
		begin
			unique case (state_q)
				SPIMDS_IDLE:
					if (fifo_valid && f_op != SPIMDS_OP_SELECT)
						state_q <= SPIMDS_SEL;
				SPIMDS_SEL:
					state_q <= SPIMDS_SHIFT;
				SPIMDS_SHIFT:
					if (tick && phase_q && bit_cnt_q == 4'h1)
						state_q <= SPIMDS_DONE;
				SPIMDS_DONE:
					state_q <= SPIMDS_IDLE;
			endcase
		end
	end

	// Select code moves only when idle.
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
			slave_position_code_q <= `SPIMDS_NULL_SLAVE_CODE;
		else if (fifo_pop)
			slave_position_code_q <= f_code;
	end

	// A return to null forgets the applied setting, so reselection reloads.
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			applied_valid_q <= 1'b0;
			applied_code_q <= `SPIMDS_NULL_SLAVE_CODE;
			act_cfg_q <= '{div: `SPIMDS_DIV_RST, cpol: 1'b0, cpha: 1'b0};
			new_stream_q <= 1'b0;
		end
		else
		begin
			new_stream_q <= 1'b0;
			if (slave_position_code_q == `SPIMDS_NULL_SLAVE_CODE)
				applied_valid_q <= 1'b0;
			else if (state_q == SPIMDS_SEL &&
				(!applied_valid_q ||
				applied_code_q != slave_position_code_q))
			begin
				act_cfg_q <= tbl_cfg;
				applied_code_q <= slave_position_code_q;
				applied_valid_q <= 1'b1;
				new_stream_q <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bit engine: each half period lasts div+1 cycles.
	assign tick = (div_cnt_q == 8'h00);

	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			div_cnt_q <= 8'h00;
			bit_cnt_q <= 4'h0;
			phase_q <= 1'b0;
			tx_sh_q <= 8'h00;
			rx_sh_q <= 8'h00;
			is_rx_q <= 1'b0;
			sclk_q <= 1'b0;
		end
		else if (fifo_pop)
		begin
			tx_sh_q <= f_data;
			is_rx_q <= (f_op == SPIMDS_OP_RX);
		end
		else if (state_q == SPIMDS_SEL)
		begin
			div_cnt_q <= act_cfg_q.div;
			bit_cnt_q <= `SPIMDS_BITS_PER_BYTE;
			phase_q <= 1'b0;
			sclk_q <= act_cfg_q.cpol;
			if (new_stream_q || !applied_valid_q ||
				applied_code_q != slave_position_code_q)
			begin
				div_cnt_q <= tbl_cfg.div;
				sclk_q <= tbl_cfg.cpol;
			end
		end
		else if (state_q == SPIMDS_SHIFT)
		begin
			div_cnt_q <= tick ? act_cfg_q.div : div_cnt_q - 8'h01;
			if (tick)
			begin
				phase_q <= !phase_q;
				sclk_q <= !sclk_q;
				// With cpha set the first bit already stands on the line, so
				// the first leading edge must not shift it away.
				if (phase_q ^ act_cfg_q.cpha)
				begin
					if (phase_q || bit_cnt_q != `SPIMDS_BITS_PER_BYTE)
						tx_sh_q <= {tx_sh_q[6:0], 1'b0};
				end
				else
					rx_sh_q <= {rx_sh_q[6:0], miso_i};
				if (phase_q)
					bit_cnt_q <= bit_cnt_q - 4'h1;
			end
		end
		else
			sclk_q <= act_cfg_q.cpol;
	end

	////////////////////////////////////////////////////////////////////////
	// Result of a receive.
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			rx_valid_q <= 1'b0;
			rx_data_q <= 8'h00;
		end
		else
		begin
			rx_valid_q <= (state_q == SPIMDS_DONE) && is_rx_q;
			if (state_q == SPIMDS_DONE && is_rx_q)
				rx_data_q <= rx_sh_q;
		end
	end

	assign {select_code_bit2_o, select_code_bit1_o, select_code_bit0_o} =
		slave_position_code_q;
	assign sclk_o = sclk_q;
	assign mosi_o = tx_sh_q[7];
	assign rx_valid_o = rx_valid_q;
	assign rx_data_o = rx_data_q;
	assign busy_o = (state_q != SPIMDS_IDLE);
	assign cfg_err_o = cfg_err_q;
	assign new_stream_o = new_stream_q;

	////////////////////////////////////////////////////////////////////////
	// Checks.
	default clocking cb_chk @(posedge core_clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_byte_end;
		state_q == SPIMDS_DONE ##1 state_q == SPIMDS_IDLE;
	endsequence

	a_sel_stable: assert property (
		state_q != SPIMDS_IDLE |=> $stable(slave_position_code_q))
		else $error("select changed during a byte");
	a_no_pop_busy: assert property (
		(busy_o && fifo_valid) |=> fifo_valid && $stable(fifo_out))
		else $error("request taken while busy");
	a_rx_result: assert property (
		(state_q == SPIMDS_DONE && is_rx_q) |=>
		rx_valid_o && rx_data_o == $past(rx_sh_q))
		else $error("receive result wrong");
	a_sel_follows: assert property (
		fifo_pop |=> slave_position_code_q == $past(f_code))
		else $error("select did not follow request");
	a_tx_sel_first: assert property (
		(fifo_pop && f_op != SPIMDS_OP_SELECT) |=>
		state_q == SPIMDS_SEL ##1 state_q == SPIMDS_SHIFT)
		else $error("byte shifted before select");
	a_select_only: assert property (
		(fifo_pop && f_op == SPIMDS_OP_SELECT) |=> state_q == SPIMDS_IDLE)
		else $error("select-only moved data");
	a_byte_end: assert property (
		state_q == SPIMDS_DONE |-> s_byte_end)
		else $error("byte end sequence broken");
	a_null_reload: assert property (
		slave_position_code_q == `SPIMDS_NULL_SLAVE_CODE |=>
		!applied_valid_q)
		else $error("null select kept setting");
	a_fixed_pos: assert property (
		(cfg_wr_i && cfg_code_i < `SPIMDS_USER_SLAVE_CODE_A) |=> cfg_err_o)
		else $error("fixed position write not refused");
	a_cfg_once: assert property (
		(state_q == SPIMDS_SEL && applied_valid_q &&
		applied_code_q == slave_position_code_q) |=> !new_stream_o)
		else $error("setting reapplied to same slave");
endmodule

//--- hdl/spimds_defs.svh
// Constants for the decoded-select SPI master.
`ifndef SPIMDS_DEFS_SVH
`define SPIMDS_DEFS_SVH
`define SPIMDS_NULL_SLAVE_CODE 3'h7
`define SPIMDS_DISPLAY_SLAVE_CODE 3'h0
`define SPIMDS_CONTROLLER_SLAVE_CODE 3'h1
`define SPIMDS_AUX_MCU_SLAVE_CODE 3'h2
`define SPIMDS_USER_SLAVE_CODE_A 3'h3
`define SPIMDS_USER_SLAVE_CODE_C 3'h5
`define SPIMDS_RESERVED_SLAVE_CODE 3'h6
`define SPIMDS_NULL_DATA 8'h00
`define SPIMDS_DIV_RST 8'h04
`define SPIMDS_FIFO_DEPTH 32
`define SPIMDS_FIFO_WIDTH 13
`define SPIMDS_BITS_PER_BYTE 4'h8
`endif

//--- hdl/spimds_pkg.sv
// Types for the decoded-select SPI master.
package spimds_pkg;
	typedef enum logic [1:0]
	{
		SPIMDS_IDLE = 2'b00,
		SPIMDS_SEL = 2'b01,
		SPIMDS_SHIFT = 2'b11,
		SPIMDS_DONE = 2'b10
	} spimds_state_t;
	typedef enum logic [1:0]
	{
		SPIMDS_OP_SELECT = 2'b00,
		SPIMDS_OP_TX = 2'b01,
		SPIMDS_OP_RX = 2'b10
	} spimds_op_t;
	typedef struct packed
	{
		logic [7:0] div;
		logic cpol;
		logic cpha;
	} spimds_cfg_t;
endpackage

//--- hdl/spimds_fifo.sv
// Request FIFO with parameterised width and depth.
`timescale 1ns/1ns
module spimds_fifo #(
	parameter int WIDTH = 13,
	parameter int DEPTH = 32
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	logic push;
	logic pop;

	assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid_o = (cnt_q != '0);
	assign out_data_o = mem_q[rd_q];
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;

	always_ff @(posedge core_clk_i)
	begin
		if (push)
			mem_q[wr_q] <= in_data_i;
	end

	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end
		else
		begin
			if (push)
				wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
			if (pop)
				rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
			if (push && !pop)
				cnt_q <= cnt_q + 1'b1;
			else if (pop && !push)
				cnt_q <= cnt_q - 1'b1;
		end
	end
endmodule

//--- hdl/spimds_cfg_table.sv
// Per-position clock settings table.
`timescale 1ns/1ns
`include "spimds_defs.svh"
module spimds_cfg_table
	import spimds_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic wr_i,
	input wire logic [2:0] wr_code_i,
	input wire logic [7:0] wr_div_i,
	input wire logic wr_cpol_i,
	input wire logic wr_cpha_i,
	input wire logic [2:0] rd_code_i,
	output spimds_cfg_t rd_cfg_o
);
	spimds_cfg_t tbl_q [8];

	generate
		for (genvar g = 0; g < 8; g++)
		begin : g_pos
			always_ff @(posedge core_clk_i or posedge rst_i)
			begin
				if (rst_i)
					tbl_q[g] <= '{div: `SPIMDS_DIV_RST, cpol: 1'b0, cpha: 1'b0};
				else if (wr_i && wr_code_i == 3'(g))
					tbl_q[g] <= '{div: wr_div_i, cpol: wr_cpol_i,
						cpha: wr_cpha_i};
			end
		end
	endgenerate

	assign rd_cfg_o = tbl_q[rd_code_i];
endmodule

//--- tb/spimds_slave_model.sv
// Behavioural slave that answers on every position but the null code.
`timescale 1ns/1ns
`include "spimds_defs.svh"
module spimds_slave_model
(
	input wire logic [2:0] sel_i,
	input wire logic sclk_i,
	// High when the slave samples on falling clock edges.
	input wire logic mode_i,
	input wire logic mosi_i,
	output logic miso_o,
	input wire logic [7:0] tx_byte_i,
	output logic [7:0] rx_byte_o,
	output int count_o
);
	logic [7:0] sh = 8'h00;
	logic [7:0] rs = 8'h00;
	int bitn = 0;
	initial
	begin
		miso_o = 1'b0;
		rx_byte_o = 8'h00;
		count_o = 0;
	end
	// A deselected line shows the inverse of its last level.
	always @(sel_i)
	begin
		if (sel_i != `SPIMDS_NULL_SLAVE_CODE)
		begin
			bitn = 0;
			sh = tx_byte_i;
			miso_o = sh[7];
		end
		else
			miso_o = ~miso_o;
	end
	// Bits are taken on one clock edge and launched on the other.
	always @(sclk_i)
	begin
		if (sel_i != `SPIMDS_NULL_SLAVE_CODE && (sclk_i ^ mode_i))
		begin
			rs = {rs[6:0], mosi_i};
			bitn = bitn + 1;
			if (bitn == 8)
			begin
				rx_byte_o = rs;
				count_o = count_o + 1;
				bitn = 0;
			end
		end
		else if (sel_i != `SPIMDS_NULL_SLAVE_CODE)
		begin
			sh = (bitn == 0) ? tx_byte_i : {sh[6:0], 1'b0};
			miso_o = sh[7];
		end
	end
endmodule

//--- tb/spi_master_decoded_select_tb.sv
// Self-checking bench for the decoded-select SPI master.
`timescale 1ns/1ns
`include "spimds_defs.svh"
`define CHK(nm, ex, got) \
	begin comparisons++; if ((got) !== (ex)) begin errors++; \
	$display("Error %s expected %0h seen %0h", nm, ex, got); end end
module spi_master_decoded_select_tb;
	logic core_clk_i, rst_i, req_valid_i, req_has_data_i, cfg_wr_i;
	logic cfg_cpol_i, cfg_cpha_i, req_ready_o, cfg_err_o, b0, b1, b2;
	logic sclk, mosi, miso, rx_valid, busy, new_stream, s_mode;
	logic [1:0] req_op_i;
	logic [2:0] req_code_i, cfg_code_i, sel;
	logic [7:0] req_data_i, cfg_div_i, rx_data, s_tx, s_rx;
	int s_cnt, errors = 0, comparisons = 0;
	int ns_cnt = 0, rx_cnt = 0, err_cnt = 0, bz_cnt = 0;
	assign sel = {b2, b1, b0};
	spimds_top spimds_top_inst (.core_clk_i(core_clk_i), .rst_i(rst_i),
		.req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
		.req_op_i(req_op_i), .req_code_i(req_code_i),
		.req_has_data_i(req_has_data_i), .req_data_i(req_data_i),
		.cfg_wr_i(cfg_wr_i), .cfg_code_i(cfg_code_i), .cfg_div_i(cfg_div_i),
		.cfg_cpol_i(cfg_cpol_i), .cfg_cpha_i(cfg_cpha_i),
		.cfg_err_o(cfg_err_o), .select_code_bit0_o(b0),
		.select_code_bit1_o(b1), .select_code_bit2_o(b2), .sclk_o(sclk),
		.mosi_o(mosi), .miso_i(miso), .rx_valid_o(rx_valid),
		.rx_data_o(rx_data), .busy_o(busy), .new_stream_o(new_stream));
	spimds_slave_model spimds_slave_model_inst (.sel_i(sel), .sclk_i(sclk),
		.mosi_i(mosi), .miso_o(miso), .tx_byte_i(s_tx), .rx_byte_o(s_rx),
		.count_o(s_cnt), .mode_i(s_mode));
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		core_clk_i = 1'b0;
		forever #5 core_clk_i = ~core_clk_i;
	end
	always @(posedge core_clk_i)
	begin
		if (new_stream === 1'b1) ns_cnt++;
		if (rx_valid === 1'b1) rx_cnt++;
		if (cfg_err_o === 1'b1) err_cnt++;
		if (busy === 1'b1) bz_cnt++;
	end
	task automatic push(input logic [1:0] op, input logic [2:0] code,
		input logic hd, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge core_clk_i);
		#1;
		req_op_i = op;
		req_code_i = code;
		req_has_data_i = hd;
		req_data_i = d;
		req_valid_i = 1'b1;
		while (req_ready_o !== 1'b1 && n < 5000)
		begin
			@(posedge core_clk_i);
			#1;
			n++;
		end
		`CHK("push ready", 1'b1, req_ready_o)
		@(posedge core_clk_i);
		#1;
		req_valid_i = 1'b0;
	endtask
	task automatic settle;
		int n, q;
		n = 0;
		q = 0;
		while (q < 4 && n < 20000)
		begin
			@(posedge core_clk_i);
			#1;
			n++;
			q = (busy === 1'b0) ? q + 1 : 0;
		end
		`CHK("settle", 1'b1, q == 4)
	endtask
	task automatic cfg(input logic [2:0] c, input logic [7:0] dv);
		@(posedge core_clk_i);
		#1;
		cfg_code_i = c;
		cfg_div_i = dv;
		cfg_wr_i = 1'b1;
		@(posedge core_clk_i);
		#1;
		cfg_wr_i = 1'b0;
		repeat (3) @(posedge core_clk_i);
		#1;
	endtask
	task automatic give_verdict;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		`CHK("select", 3'h7, sel)
		`CHK("ready", 1'b1, req_ready_o)
		`CHK("busy", 1'b0, busy)
		`CHK("sclk", 1'b0, sclk)
		$display("test reset done");
	endtask
	task automatic t_select;
		int c0;
		c0 = s_cnt;
		push(2'h0, 3'h3, 1'b0, 8'h00);
		settle();
		`CHK("select", 3'h3, sel)
		`CHK("bytes", c0, s_cnt)
		push(2'h0, 3'h7, 1'b0, 8'h00);
		settle();
		`CHK("select", 3'h7, sel)
		$display("test select done");
	endtask
	task automatic t_tx;
		int c0;
		c0 = s_cnt;
		push(2'h1, 3'h4, 1'b1, 8'h78);
		repeat (3) @(posedge core_clk_i);
		#1;
		`CHK("select", 3'h4, sel)
		`CHK("busy", 1'b1, busy)
		settle();
		`CHK("slave byte", 8'h78, s_rx)
		`CHK("bytes", c0 + 1, s_cnt)
		$display("test transmit done");
	endtask
	task automatic t_rx;
		int r0;
		r0 = rx_cnt;
		s_tx = 8'h3c;
		push(2'h2, 3'h3, 1'b1, 8'ha5);
		settle();
		`CHK("rx data", 8'h3c, rx_data)
		`CHK("rx pulses", r0 + 1, rx_cnt)
		`CHK("slave byte", 8'ha5, s_rx)
		s_tx = 8'hc3;
		push(2'h2, 3'h5, 1'b0, 8'hff);
		settle();
		`CHK("slave byte", 8'h00, s_rx)
		`CHK("rx data", 8'hc3, rx_data)
		$display("test receive done");
	endtask
	task automatic t_stream;
		int n0, c0;
		push(2'h1, 3'h5, 1'b1, 8'h11);
		settle();
		n0 = ns_cnt;
		c0 = s_cnt;
		push(2'h1, 3'h5, 1'b1, 8'h22);
		push(2'h1, 3'h5, 1'b1, 8'h33);
		settle();
		`CHK("settings reapplied", n0, ns_cnt)
		`CHK("bytes", c0 + 2, s_cnt)
		`CHK("slave byte", 8'h33, s_rx)
		push(2'h0, 3'h7, 1'b0, 8'h00);
		settle();
		n0 = ns_cnt;
		push(2'h1, 3'h5, 1'b1, 8'h44);
		settle();
		`CHK("new stream", 1'b1, ns_cnt != n0)
		$display("test stream done");
	endtask
	task automatic t_cfg;
		logic [2:0] bad [5] = '{3'h0, 3'h1, 3'h2, 3'h6, 3'h7};
		int e0;
		foreach (bad[i])
		begin
			e0 = err_cnt;
			cfg(bad[i], 8'h02);
			`CHK("cfg refused", e0 + 1, err_cnt)
		end
		e0 = err_cnt;
		cfg(3'h3, 8'h01);
		`CHK("cfg accepted", e0, err_cnt)
		push(2'h1, 3'h3, 1'b1, 8'h5a);
		settle();
		`CHK("slave byte", 8'h5a, s_rx)
		$display("test config done");
	endtask
	task automatic t_fill;
		int c0, p;
		logic full;
		c0 = s_cnt;
		p = 0;
		full = 1'b0;
		@(posedge core_clk_i);
		#1;
		req_op_i = 2'h1;
		req_code_i = 3'h4;
		req_data_i = 8'h96;
		req_valid_i = 1'b1;
		repeat (40)
		begin
			if (req_ready_o === 1'b1) p++;
			else full = 1'b1;
			@(posedge core_clk_i);
			#1;
		end
		req_valid_i = 1'b0;
		`CHK("full seen", 1'b1, full)
		`CHK("accepted", 33, p)
		settle();
		`CHK("drained", c0 + p, s_cnt)
		$display("test fill done");
	endtask
	task automatic t_mode;
		int r0, b0;
		r0 = rx_cnt;
		cfg_cpha_i = 1'b1;
		cfg(3'h4, 8'h02);
		cfg_cpha_i = 1'b0;
		s_mode = 1'b1;
		s_tx = 8'h69;
		b0 = bz_cnt;
		push(2'h0, 3'h7, 1'b0, 8'h00);
		push(2'h2, 3'h4, 1'b1, 8'hb4);
		settle();
		`CHK("rx data", 8'h69, rx_data)
		`CHK("slave byte", 8'hb4, s_rx)
		`CHK("rx pulses", r0 + 1, rx_cnt)
		`CHK("busy cycles", 50, bz_cnt - b0)
		$display("test clock phase done");
	endtask
	initial
	begin
		#300000;
		errors++;
		give_verdict();
	end
	initial
	begin
		rst_i = 1'b1;
		req_valid_i = 1'b0;
		req_op_i = 2'h0;
		req_code_i = 3'h7;
		req_has_data_i = 1'b0;
		req_data_i = 8'h00;
		cfg_wr_i = 1'b0;
		cfg_code_i = 3'h3;
		cfg_div_i = 8'h04;
		cfg_cpol_i = 1'b0;
		cfg_cpha_i = 1'b0;
		s_tx = 8'h00;
		s_mode = 1'b0;
		repeat (8) @(posedge core_clk_i);
		#1;
		rst_i = 1'b0;
		t_reset();
		t_select();
		t_tx();
		t_rx();
		t_stream();
		t_cfg();
		t_fill();
		t_mode();
		give_verdict();
	end
endmodule
